// ==== logic/pxb_crossbar.sv ====
// priority decoder giving each requested slot the lowest free pin
`timescale 1ns/1ns
module pxb_crossbar (
  // requests
  input wire logic [pxb_pkg::SLOT_N-1:0] slot_req,
  input wire logic [pxb_pkg::PIN_N-1:0] skip,
  input wire logic uart_fixed,
  // assignment
  output logic [pxb_pkg::PIN_N-1:0] pin_has,
  output logic [pxb_pkg::PIN_N-1:0][pxb_pkg::SLOT_W-1:0] pin_slot
);
  import pxb_pkg::*;

  logic [PIN_N-1:0] used;
  logic found;

  always_comb begin
    used = skip | (uart_fixed ? UART_PINS : 8'h00);
    found = 1'b0;
    pin_has = '0;
    pin_slot = '0;
    for (int s = 0; s < SLOT_N; s++) begin
      found = 1'b0;
      if (slot_req[s]) begin
        for (int p = 0; p < PIN_N; p++) begin
          if (!found && !used[p]) begin
            used[p] = 1'b1;
            pin_has[p] = 1'b1;
            pin_slot[p] = SLOT_W'(s);
            found = 1'b1;
          end
        end
      end
    end
  end
endmodule : pxb_crossbar

// ==== logic/pxb_pkg.sv ====
// constants and helpers for the port crossbar and match block
// What this block does
// - uart pins fixed at pin four and five
// - spi takes three or four pins
// - two wire pins always open drain
// - clock output routed only when enabled
// - four bits route comparator outputs
// - pullup disable bit kills every weak pullup
// - crossbar enable gates all peripheral assignment
// - timer and count inputs each routed
// - array field n routes channels below n, seven routes none
// - latch drives free pins, od high floats
// - normal read returns pin levels
// - read modify write reads the latch
// - analog pins read zero, digital read pin
// - input mode zero with latch bit one makes pin analog
// - output mode picks od or push pull
// - skip bit removes pin from assignment
// - masked mismatch raises match event
// - mask zero excludes pin from compare
// - match event requests irq when irq enable is set
// - lowest free unskipped pin per peripheral
// - drivers off while crossbar disabled
// - no pullup on low driven pins
package pxb_pkg;
  // ************************************
  // sizes
  // ************************************
  localparam int PIN_N = 8;
  localparam int SLOT_N = 20;
  localparam int SLOT_W = 5;
  localparam int CEX_N = 6;
  // ************************************
  // register addresses and resets
  // ************************************
  localparam logic [7:0] ADDR_DATA = 8'h80;
  localparam logic [7:0] ADDR_OUT_MODE = 8'ha4;
  localparam logic [7:0] ADDR_MASK = 8'hc7;
  localparam logic [7:0] ADDR_SKIP = 8'hd4;
  localparam logic [7:0] ADDR_VALUE = 8'hd7;
  localparam logic [7:0] ADDR_ROUTE_LO = 8'he1;
  localparam logic [7:0] ADDR_ROUTE_HI = 8'he2;
  localparam logic [7:0] ADDR_IN_MODE = 8'hf1;
  localparam logic [7:0] RST_DATA = 8'hff;
  localparam logic [7:0] RST_OUT_MODE = 8'h00;
  localparam logic [7:0] RST_MASK = 8'h00;
  localparam logic [7:0] RST_SKIP = 8'h00;
  localparam logic [7:0] RST_VALUE = 8'hff;
  localparam logic [7:0] RST_ROUTE = 8'h00;
  localparam logic [7:0] RST_IN_MODE = 8'hff;
  // ************************************
  // route enable bit positions
  // ************************************
  localparam int B_UART = 0;
  localparam int B_SPI = 1;
  localparam int B_SMB = 2;
  localparam int B_CLKO = 3;
  localparam int B_CMP0S = 4;
  localparam int B_CMP0A = 5;
  localparam int B_CMP1S = 6;
  localparam int B_CMP1A = 7;
  localparam int B_ARRAY_LO = 0;
  localparam int B_ARRAY_HI = 2;
  localparam int B_ECI = 3;
  localparam int B_T0 = 4;
  localparam int B_T1 = 5;
  localparam int B_XBAR = 6;
  localparam int B_WPUD = 7;
  localparam logic [2:0] ARRAY_RSVD = 3'h7;
  // ************************************
  // slots in priority order
  // ************************************
  localparam int S_SPI = 0;
  localparam int S_NSS = 3;
  localparam int S_SDA = 4;
  localparam int S_SCL = 5;
  localparam int S_CMP0S = 6;
  localparam int S_CMP0A = 7;
  localparam int S_CMP1S = 8;
  localparam int S_CMP1A = 9;
  localparam int S_CLKO = 10;
  localparam int S_CEX = 11;
  localparam int S_ECI = 17;
  localparam int S_T0 = 18;
  localparam int S_T1 = 19;
  localparam logic [19:0] SLOT_OD_MASK = 20'h00030;
  localparam int UART_TX_PIN = 4;
  localparam int UART_RX_PIN = 5;
  localparam logic [7:0] UART_PINS = 8'h30;

  // open drain drives only a low; returns {oe, out}
  function automatic logic [1:0] pxb_drive_fn(input logic v, input logic req, input logic od);
    pxb_drive_fn = {req & (~od | ~v), v};
  endfunction : pxb_drive_fn
endpackage : pxb_pkg

// ==== logic/pxb_port_top.sv ====
// port zero pin logic, crossbar routing, readback and match event
`timescale 1ns/1ns
module pxb_port_top (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // special function register access
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic sfr_rmw,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  // pins
  input wire logic [pxb_pkg::PIN_N-1:0] pin_in,
  output logic [pxb_pkg::PIN_N-1:0] pin_out,
  output logic [pxb_pkg::PIN_N-1:0] pin_oe,
  output logic [pxb_pkg::PIN_N-1:0] pin_pullup,
  // uart
  input wire logic uart_tx,
  output logic uart_rx,
  // spi: sck, miso, mosi, slave select
  input wire logic spi_four_wire,
  input wire logic [3:0] spi_out,
  input wire logic [3:0] spi_oe,
  output logic [3:0] spi_in,
  // two wire bus
  input wire logic sda_out,
  input wire logic scl_out,
  output logic sda_in,
  output logic scl_in,
  // comparators and clock output
  input wire logic cmp0_sync,
  input wire logic cmp0_async,
  input wire logic cmp1_sync,
  input wire logic cmp1_async,
  input wire logic sysclk_inv,
  // counter array and timers
  input wire logic [pxb_pkg::CEX_N-1:0] array_channel_out,
  output logic [pxb_pkg::CEX_N-1:0] array_channel_in,
  output logic ext_count_input,
  output logic timer0_input,
  output logic timer1_input,
  // match event
  input wire logic port1_match,
  input wire logic match_irq_enable,
  output logic port_match,
  output logic match_irq
);
  import pxb_pkg::*;

  typedef struct packed {
    logic [PIN_N-1:0] out;
    logic [PIN_N-1:0] oe;
    logic [PIN_N-1:0] pull;
    logic [7:0] rdata;
    logic [SLOT_N-1:0] sin;
    logic urx;
    logic match;
    logic irq;
  } pxb_top_type;

  pxb_top_type st_q;
  pxb_top_type st_d;

  logic [7:0] latch;
  logic [7:0] omode;
  logic [7:0] mask;
  logic [7:0] skip;
  logic [7:0] value;
  logic [7:0] rlo;
  logic [7:0] rhi;
  logic [7:0] imode;
  logic xbar_en;
  logic uart_en;
  logic [2:0] array_n;
  logic [SLOT_N-1:0] slot_req;
  logic [SLOT_N-1:0] slot_val;
  logic [SLOT_N-1:0] slot_drv;
  logic [PIN_N-1:0] pin_has;
  logic [PIN_N-1:0][SLOT_W-1:0] pin_slot;
  logic [PIN_N-1:0] analog;
  logic [PIN_N-1:0] din;

  // ************************************
  // registers and crossbar
  // ************************************
  pxb_sfr_regs u_regs (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .sfr_wr(sfr_wr),
    .sfr_addr(sfr_addr),
    .sfr_wdata(sfr_wdata),
    .data_latch(latch),
    .out_mode(omode),
    .cmp_mask(mask),
    .xbar_skip(skip),
    .cmp_value(value),
    .route_lo(rlo),
    .route_hi(rhi),
    .in_mode(imode)
  );

  pxb_crossbar u_xbar (
    .slot_req(slot_req),
    .skip(skip),
    .uart_fixed(uart_en),
    .pin_has(pin_has),
    .pin_slot(pin_slot)
  );

  // ************************************
  // slot requests
  // ************************************
  assign xbar_en = rhi[B_XBAR];
  assign uart_en = xbar_en & rlo[B_UART];
  assign array_n = rhi[B_ARRAY_HI:B_ARRAY_LO];
  assign analog = ~imode & latch;
  assign din = pin_in & ~analog;

  always_comb begin
    slot_req = '0;
    slot_req[S_SPI +: 3] = {3{rlo[B_SPI]}};
    slot_req[S_NSS] = rlo[B_SPI] & spi_four_wire;
    slot_req[S_SDA] = rlo[B_SMB];
    slot_req[S_SCL] = rlo[B_SMB];
    slot_req[S_CMP0S] = rlo[B_CMP0S];
    slot_req[S_CMP0A] = rlo[B_CMP0A];
    slot_req[S_CMP1S] = rlo[B_CMP1S];
    slot_req[S_CMP1A] = rlo[B_CMP1A];
    slot_req[S_CLKO] = rlo[B_CLKO];
    for (int c = 0; c < CEX_N; c++) begin
      slot_req[S_CEX + c] = (array_n != ARRAY_RSVD) && (c < int'(array_n));
    end
    slot_req[S_ECI] = rhi[B_ECI];
    slot_req[S_T0] = rhi[B_T0];
    slot_req[S_T1] = rhi[B_T1];
    slot_req = xbar_en ? slot_req : '0;
  end

  // slot index order fixes the priority
  assign slot_val = {3'b111, array_channel_out, sysclk_inv, cmp1_async, cmp1_sync,
                     cmp0_async, cmp0_sync, scl_out, sda_out, spi_out};
  assign slot_drv = {3'b000, 6'h3f, 1'b1, 4'hf, 2'b11, spi_oe};

  // ************************************
  // next state
  // ************************************
  always_comb begin
    logic v;
    logic r;
    logic od;
    logic [1:0] drv;
    v = 1'b1;
    r = 1'b0;
    od = 1'b0;
    drv = 2'b00;
    st_d = st_q;
    st_d.sin = '1;
    for (int p = 0; p < PIN_N; p++) begin
      od = ~omode[p];
      if (uart_en && p == UART_TX_PIN) begin
        v = uart_tx;
        r = 1'b1;
      end else if (uart_en && p == UART_RX_PIN) begin
        v = 1'b1;
        r = 1'b0;
      end else if (pin_has[p]) begin
        v = slot_val[pin_slot[p]];
        r = slot_drv[pin_slot[p]];
        od = od | SLOT_OD_MASK[pin_slot[p]];
        st_d.sin[pin_slot[p]] = din[p];
      end else begin
        v = latch[p];
        r = 1'b1;
      end
      drv = pxb_drive_fn(v, r, od);
      st_d.out[p] = drv[0];
      st_d.oe[p] = drv[1] & xbar_en & ~analog[p];
      st_d.pull[p] = ~rhi[B_WPUD] & ~analog[p] & ~(st_d.oe[p] & ~drv[0]);
    end
    st_d.urx = uart_en ? din[UART_RX_PIN] : 1'b1;
    st_d.match = ((din & mask) != (value & mask)) | port1_match;
    st_d.irq = st_d.match & match_irq_enable;
    if (sfr_rd) begin
      if (sfr_addr == ADDR_DATA) begin
        st_d.rdata = sfr_rmw ? latch : din;
      end else if (sfr_addr == ADDR_OUT_MODE) begin
        st_d.rdata = omode;
      end else if (sfr_addr == ADDR_MASK) begin
        st_d.rdata = mask;
      end else if (sfr_addr == ADDR_SKIP) begin
        st_d.rdata = skip;
      end else if (sfr_addr == ADDR_VALUE) begin
        st_d.rdata = value;
      end else if (sfr_addr == ADDR_ROUTE_LO) begin
        st_d.rdata = rlo;
      end else if (sfr_addr == ADDR_ROUTE_HI) begin
        st_d.rdata = rhi;
      end else if (sfr_addr == ADDR_IN_MODE) begin
        st_d.rdata = imode;
      end else begin
        st_d.rdata = 8'h00;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      st_q <= '{out: '1, oe: '0, pull: '0, rdata: 8'h00, sin: '1,
                urx: 1'b1, match: 1'b0, irq: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  // ************************************
  // outputs
  // ************************************
  assign sfr_rdata = st_q.rdata;
  assign pin_out = st_q.out;
  assign pin_oe = st_q.oe;
  assign pin_pullup = st_q.pull;
  assign uart_rx = st_q.urx;
  assign spi_in = st_q.sin[S_NSS:S_SPI];
  assign sda_in = st_q.sin[S_SDA];
  assign scl_in = st_q.sin[S_SCL];
  assign array_channel_in = st_q.sin[S_CEX +: CEX_N];
  assign ext_count_input = st_q.sin[S_ECI];
  assign timer0_input = st_q.sin[S_T0];
  assign timer1_input = st_q.sin[S_T1];
  assign port_match = st_q.match;
  assign match_irq = st_q.irq;

  // ************************************
  // assertions
  // ************************************
  property p_drivers_off;
    @(posedge sys_clk) disable iff (!resetn)
    !xbar_en |=> pin_oe == 8'h00;
  endproperty
  a_drivers_off: assert property (p_drivers_off) else $error("driver on with crossbar off");

  property p_uart_tx;
    @(posedge sys_clk) disable iff (!resetn)
    uart_en && omode[UART_TX_PIN] && !analog[UART_TX_PIN]
      |=> pin_oe[UART_TX_PIN] && pin_out[UART_TX_PIN] == $past(uart_tx);
  endproperty
  a_uart_tx: assert property (p_uart_tx) else $error("uart tx not on its fixed pin");

  property p_analog_quiet;
    @(posedge sys_clk) disable iff (!resetn)
    analog != 8'h00 |=> ((pin_oe | pin_pullup) & $past(analog)) == 8'h00;
  endproperty
  a_analog_quiet: assert property (p_analog_quiet) else $error("analog pin driven");

  property p_match;
    @(posedge sys_clk) disable iff (!resetn)
    1'b1 |=> port_match == ($past(((din ^ value) & mask) != 8'h00) || $past(port1_match));
  endproperty
  a_match: assert property (p_match) else $error("match event wrong");

  property p_read_pins;
    @(posedge sys_clk) disable iff (!resetn)
    sfr_rd && sfr_addr == ADDR_DATA && !sfr_rmw |=> sfr_rdata == $past(pin_in & ~analog);
  endproperty
  a_read_pins: assert property (p_read_pins) else $error("port read not pin level");

  property p_read_latch;
    @(posedge sys_clk) disable iff (!resetn)
    sfr_rd && sfr_addr == ADDR_DATA && sfr_rmw |=> sfr_rdata == $past(latch);
  endproperty
  a_read_latch: assert property (p_read_latch) else $error("rmw read not latch");

  property p_no_pull_low;
    @(posedge sys_clk) disable iff (!resetn)
    (pin_oe & ~pin_out & pin_pullup) == 8'h00;
  endproperty
  a_no_pull_low: assert property (p_no_pull_low) else $error("pullup on low pin");

  property p_pull_off;
    @(posedge sys_clk) disable iff (!resetn)
    rhi[B_WPUD] |=> pin_pullup == 8'h00;
  endproperty
  a_pull_off: assert property (p_pull_off) else $error("pullup with disable set");

  property p_irq;
    @(posedge sys_clk) disable iff (!resetn)
    match_irq |-> port_match && $past(match_irq_enable);
  endproperty
  a_irq: assert property (p_irq) else $error("irq without enabled match");

  property p_uart_rx;
    @(posedge sys_clk) disable iff (!resetn)
    uart_en |=> !pin_oe[UART_RX_PIN];
  endproperty
  a_uart_rx: assert property (p_uart_rx) else $error("uart rx pin driven");

  property p_irq_follow;
    @(posedge sys_clk) disable iff (!resetn)
    match_irq_enable |=> match_irq == port_match;
  endproperty
  a_irq_follow: assert property (p_irq_follow) else $error("irq not following match");
endmodule : pxb_port_top

// ==== logic/pxb_sfr_regs.sv ====
// special function register storage for port zero and crossbar
`timescale 1ns/1ns
module pxb_sfr_regs (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // write port
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  // register values
  output logic [7:0] data_latch,
  output logic [7:0] out_mode,
  output logic [7:0] cmp_mask,
  output logic [7:0] xbar_skip,
  output logic [7:0] cmp_value,
  output logic [7:0] route_lo,
  output logic [7:0] route_hi,
  output logic [7:0] in_mode
);
  import pxb_pkg::*;

  typedef struct packed {
    logic [7:0] data;
    logic [7:0] omode;
    logic [7:0] mask;
    logic [7:0] skip;
    logic [7:0] value;
    logic [7:0] rlo;
    logic [7:0] rhi;
    logic [7:0] imode;
  } pxb_regs_type;

  pxb_regs_type st_q;
  pxb_regs_type st_d;

  // ************************************
  // write decode
  // ************************************
  always_comb begin
    st_d = st_q;
    if (sfr_wr) begin
      if (sfr_addr == ADDR_DATA) begin
        st_d.data = sfr_wdata;
      end else if (sfr_addr == ADDR_OUT_MODE) begin
        st_d.omode = sfr_wdata;
      end else if (sfr_addr == ADDR_MASK) begin
        st_d.mask = sfr_wdata;
      end else if (sfr_addr == ADDR_SKIP) begin
        st_d.skip = sfr_wdata;
      end else if (sfr_addr == ADDR_VALUE) begin
        st_d.value = sfr_wdata;
      end else if (sfr_addr == ADDR_ROUTE_LO) begin
        st_d.rlo = sfr_wdata;
      end else if (sfr_addr == ADDR_ROUTE_HI) begin
        st_d.rhi = sfr_wdata;
      end else if (sfr_addr == ADDR_IN_MODE) begin
        st_d.imode = sfr_wdata;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      st_q <= '{RST_DATA, RST_OUT_MODE, RST_MASK, RST_SKIP, RST_VALUE,
                RST_ROUTE, RST_ROUTE, RST_IN_MODE};
    end else begin
      st_q <= st_d;
    end
  end

  assign data_latch = st_q.data;
  assign out_mode = st_q.omode;
  assign cmp_mask = st_q.mask;
  assign xbar_skip = st_q.skip;
  assign cmp_value = st_q.value;
  assign route_lo = st_q.rlo;
  assign route_hi = st_q.rhi;
  assign in_mode = st_q.imode;
endmodule : pxb_sfr_regs

// ==== testbench/pxb_board.sv ====
// board model: resolves pad levels from device drivers, pullups and outside drive
`timescale 1ns/1ns
module pxb_board (
  // clock
  input wire logic sys_clk,
  // device side
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] pin_pullup,
  // outside drive
  input wire logic [7:0] ext_oe,
  input wire logic [7:0] ext_val,
  // pad level
  output logic [7:0] pin_in
);
  logic [7:0] last_q = 8'h00;
  always_ff @(posedge sys_clk) last_q <= pin_in;
  // undriven pads without pullup wander, never hold
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pin_oe[i]) pin_in[i] = pin_out[i];
      else if (ext_oe[i]) pin_in[i] = ext_val[i];
      else if (pin_pullup[i]) pin_in[i] = 1'b1;
      else pin_in[i] = ~last_q[i];
    end
  end
endmodule : pxb_board

// ==== testbench/pxb_port_top_tb.sv ====
// self-checking bench for the port crossbar and match block
`timescale 1ns/1ns
module pxb_port_top_tb;
  import pxb_pkg::*;
  // ************************************
  // signals
  // ************************************
  logic sys_clk, resetn, sfr_wr, sfr_rd, sfr_rmw, uart_tx, uart_rx, spi_four_wire;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, pin_in, pin_out, pin_oe, pin_pullup;
  logic [7:0] ext_oe, ext_val, rd_v;
  logic [3:0] spi_out, spi_oe, spi_in;
  logic sda_out, scl_out, sda_in, scl_in;
  logic cmp0_sync, cmp0_async, cmp1_sync, cmp1_async, sysclk_inv;
  logic [CEX_N-1:0] array_channel_out, array_channel_in;
  logic ext_count_input, timer0_input, timer1_input;
  logic port1_match, match_irq_enable, port_match, match_irq;
  int miscompares = 0;
  int cmp_count = 0;
  // ************************************
  // design and board
  // ************************************
  pxb_port_top dut_u (.sys_clk(sys_clk), .resetn(resetn), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_rmw(sfr_rmw), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup),
    .uart_tx(uart_tx), .uart_rx(uart_rx), .spi_four_wire(spi_four_wire),
    .spi_out(spi_out), .spi_oe(spi_oe), .spi_in(spi_in), .sda_out(sda_out),
    .scl_out(scl_out), .sda_in(sda_in), .scl_in(scl_in), .cmp0_sync(cmp0_sync),
    .cmp0_async(cmp0_async), .cmp1_sync(cmp1_sync), .cmp1_async(cmp1_async),
    .sysclk_inv(sysclk_inv), .array_channel_out(array_channel_out),
    .array_channel_in(array_channel_in), .ext_count_input(ext_count_input),
    .timer0_input(timer0_input), .timer1_input(timer1_input), .port1_match(port1_match),
    .match_irq_enable(match_irq_enable), .port_match(port_match), .match_irq(match_irq));
  pxb_board board_u (.sys_clk(sys_clk), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pullup(pin_pullup), .ext_oe(ext_oe), .ext_val(ext_val), .pin_in(pin_in));
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  // ************************************
  // bus and check tasks
  // ************************************
  task automatic chk8(input logic [7:0] got, input logic [7:0] e);
    cmp_count++;
    if (got !== e) begin
      miscompares++;
      $display("Error %0t: got %h expected %h", $time, got, e);
    end
  endtask : chk8
  task automatic settle;
    repeat (3) @(negedge sys_clk);
  endtask : settle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    {sfr_wr, sfr_addr, sfr_wdata} = {1'b1, a, d};
    @(negedge sys_clk);
    sfr_wr = 1'b0;
  endtask : wr
  task automatic rchk(input logic [7:0] a, input logic m, input logic [7:0] e);
    @(negedge sys_clk);
    {sfr_rd, sfr_rmw, sfr_addr} = {1'b1, m, a};
    @(negedge sys_clk);
    {sfr_rd, sfr_rmw} = 2'b00;
    rd_v = sfr_rdata;
    chk8(rd_v, e);
  endtask : rchk
  task automatic cfg(input logic [7:0] lo, hi, skp, mode, data);
    wr(ADDR_ROUTE_LO, lo);
    wr(ADDR_ROUTE_HI, hi);
    wr(ADDR_SKIP, skp);
    wr(ADDR_OUT_MODE, mode);
    wr(ADDR_DATA, data);
    settle;
  endtask : cfg
  task automatic wchk(input logic [7:0] a, input logic [7:0] d, input logic [7:0] e);
    wr(a, d);
    settle;
    chk8(pin_out & pin_oe, e);
  endtask : wchk
  task automatic mchk(input logic [7:0] e);
    settle;
    chk8({6'h0, port_match, match_irq}, e);
  endtask : mchk
  // ************************************
  // scenarios
  // ************************************
  task automatic t_reset;
    chk8(pin_oe, 8'h00);
    chk8(pin_pullup, 8'hff);
    rchk(ADDR_DATA, 1'b1, 8'hff);
    rchk(ADDR_OUT_MODE, 1'b0, 8'h00);
    rchk(ADDR_MASK, 1'b0, 8'h00);
    rchk(ADDR_SKIP, 1'b0, 8'h00);
    rchk(ADDR_VALUE, 1'b0, 8'hff);
    rchk(ADDR_ROUTE_LO, 1'b0, 8'h00);
    rchk(ADDR_ROUTE_HI, 1'b0, 8'h00);
    rchk(ADDR_IN_MODE, 1'b0, 8'hff);
    rchk(8'h81, 1'b0, 8'h00);
  endtask : t_reset
  task automatic t_gpio;
    cfg(8'hff, 8'h3e, 8'h00, 8'hff, 8'h00);
    chk8(pin_oe, 8'h00);
    cfg(8'h00, 8'h40, 8'h00, 8'hf0, 8'ha5);
    chk8(pin_oe, 8'hfa);
    chk8(pin_out & pin_oe, 8'ha0);
    chk8(pin_pullup, 8'ha5);
    rchk(ADDR_DATA, 1'b0, 8'ha5);
    wr(ADDR_ROUTE_HI, 8'hc0);
    settle;
    chk8(pin_pullup, 8'h00);
  endtask : t_gpio
  task automatic t_read;
    {ext_oe, ext_val} = {8'h0f, 8'h03};
    cfg(8'h00, 8'h40, 8'h00, 8'h00, 8'hff);
    rchk(ADDR_DATA, 1'b0, 8'hf3);
    rchk(ADDR_DATA, 1'b1, 8'hff);
    wr(ADDR_IN_MODE, 8'h0f);
    settle;
    rchk(ADDR_DATA, 1'b0, 8'h03);
    chk8(pin_pullup, 8'h0f);
    rchk(ADDR_DATA, 1'b1, 8'hff);
    wr(ADDR_IN_MODE, 8'hff);
    ext_oe = 8'h00;
  endtask : t_read
  task automatic t_uart_spi;
    {uart_tx, spi_four_wire, spi_out, spi_oe} = {1'b1, 1'b1, 4'hd, 4'hd};
    {ext_oe, ext_val} = {8'h28, 8'h08};
    cfg(8'h03, 8'h40, 8'h06, 8'hff, 8'h00);
    chk8(pin_oe & 8'hf9, 8'hd1);
    chk8(pin_out & 8'hd9, 8'hd1);
    chk8({7'h0, uart_rx}, 8'h00);
    chk8({4'h0, spi_in}, 8'h0f);
    spi_four_wire = 1'b0;
    settle;
    chk8(pin_out & 8'hd9, 8'h51);
    ext_oe = 8'h00;
  endtask : t_uart_spi
  task automatic t_smb_cmp;
    {sda_out, scl_out} = 2'b01;
    cfg(8'h04, 8'h40, 8'h01, 8'hff, 8'hff);
    chk8(pin_oe & 8'h06, 8'h02);
    chk8({6'h0, sda_in, scl_in}, 8'h01);
    {cmp0_sync, cmp0_async, cmp1_sync, cmp1_async, sysclk_inv} = 5'b10101;
    cfg(8'hf8, 8'h40, 8'h00, 8'hff, 8'h00);
    chk8(pin_out & pin_oe, 8'h15);
    wchk(ADDR_ROUTE_LO, 8'h08, 8'h01);
    wchk(ADDR_ROUTE_LO, 8'h00, 8'h00);
  endtask : t_smb_cmp
  task automatic t_array;
    logic [7:0] e;
    array_channel_out = 6'h3f;
    cfg(8'h00, 8'h40, 8'h00, 8'hff, 8'h00);
    for (int n = 0; n < 8; n++) begin
      e = (n == 7) ? 8'h00 : 8'((1 << n) - 1);
      wchk(ADDR_ROUTE_HI, 8'h40 | 8'(n), e);
    end
    array_channel_out = 6'h15;
    wchk(ADDR_ROUTE_HI, 8'h46, 8'h15);
    chk8({2'h0, array_channel_in}, 8'h15);
    {ext_oe, ext_val} = {8'h07, 8'h02};
    wr(ADDR_ROUTE_HI, 8'h78);
    settle;
    chk8({5'h0, ext_count_input, timer0_input, timer1_input}, 8'h02);
    chk8(pin_oe & 8'h07, 8'h00);
  endtask : t_array
  task automatic t_match;
    {ext_oe, ext_val, match_irq_enable} = {8'hff, 8'h5a, 1'b1};
    cfg(8'h00, 8'h40, 8'h00, 8'h00, 8'hff);
    wr(ADDR_MASK, 8'h0f);
    wr(ADDR_VALUE, 8'h0a);
    mchk(8'h00);
    wr(ADDR_VALUE, 8'h0b);
    mchk(8'h03);
    match_irq_enable = 1'b0;
    mchk(8'h02);
    wr(ADDR_MASK, 8'h00);
    mchk(8'h00);
    port1_match = 1'b1;
    mchk(8'h02);
  endtask : t_match
  task automatic results;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : results
  // ************************************
  // main sequence and watchdog
  // ************************************
  initial begin
    {resetn, sfr_wr, sfr_rd, sfr_rmw, sfr_addr, sfr_wdata} = '0;
    {uart_tx, spi_four_wire, spi_out, spi_oe, sda_out, scl_out} = '0;
    {cmp0_sync, cmp0_async, cmp1_sync, cmp1_async, sysclk_inv} = '0;
    {array_channel_out, port1_match, match_irq_enable, ext_oe, ext_val} = '0;
    repeat (8) @(posedge sys_clk);
    @(negedge sys_clk);
    resetn = 1'b1;
    settle;
    t_reset;
    t_gpio;
    t_read;
    t_uart_spi;
    t_smb_cmp;
    t_array;
    t_match;
    results;
  end
  initial begin
    repeat (100000) @(posedge sys_clk);
    miscompares++;
    results;
  end
endmodule : pxb_port_top_tb
